// file: hw/key_repeat.sv
module key_repeat
    import weld_panel_pkg::*;
#(
    parameter int REPEAT_CYCLES_P = REPEAT_CYCLES,
    parameter int HOLD_TICKS_P    = HOLD_TICKS
)
(
    input  wire logic clock,
    input  wire logic srst,
    key_step_if.rpt   keys
);
    localparam int CW = $clog2(REPEAT_CYCLES_P + 1);
    localparam int HW = $clog2(HOLD_TICKS_P + 1);

    logic          held;       // one arrow down; both count as none
    logic          held_prev;  // held one cycle ago, for the press edge
    logic [CW-1:0] rpt_cnt;    // quarter-second divider
    logic [HW-1:0] hold_cnt;   // repeat ticks seen during this hold
    logic          tick;       // one-cycle enable at each repeat period

    assign held = keys.up ^ keys.down;
    assign tick = held && (rpt_cnt == CW'(REPEAT_CYCLES_P - 1));

    // press edge tracker
    always_ff @(posedge clock)
    begin
        if (srst)
            held_prev <= 1'b0;
        else
            held_prev <= held;
    end

    // repeat divider, restarted on every release
    always_ff @(posedge clock)
    begin
        if (srst || !held)
            rpt_cnt <= '0;  // RULE22
        else if (tick)
            rpt_cnt <= '0;
        else
            rpt_cnt <= rpt_cnt + 1'b1;  // RULE22
    end

    // hold timer in ticks; saturates so a long hold stays big
    always_ff @(posedge clock)
    begin
        if (srst || !held)
            hold_cnt <= '0;  // RULE22
        else if (tick && (hold_cnt < HW'(HOLD_TICKS_P)))
            hold_cnt <= hold_cnt + 1'b1;
    end

    // step pulse: once on the press, then once per tick while held
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            keys.step     <= 1'b0;
            keys.step_up  <= 1'b0;
            keys.step_big <= 1'b0;
        end
        else
        begin
            keys.step     <= (held && !held_prev) || tick;  // RULE5 RULE6 RULE15
            keys.step_up  <= keys.up;
            // the tick that completes four seconds already takes the big step
            keys.step_big <= tick && ((hold_cnt + 1'b1) >= HW'(HOLD_TICKS_P));  // RULE7
        end
    end

endmodule : key_repeat

// file: hw/key_step_if.sv
// arrow key levels out to the repeat engine, edit steps back
interface key_step_if;
    logic up;        // up arrow held, synchronised level
    logic down;      // down arrow held, synchronised level
    logic step;      // one-cycle pulse: apply one edit step
    logic step_up;   // direction of the step
    logic step_big;  // step is the large one

    modport rpt (input up, down, output step, step_up, step_big);
    modport ctl (output up, down, input step, step_up, step_big);
endinterface : key_step_if

// file: hw/weld_panel.sv
// Overview of operation
// RULE1: start input enables output
// RULE2: output holds until start drops
// RULE3: power-up shows stored amplitude
// RULE4: config key steps display modes
// RULE5: arrow press steps amplitude by one
// RULE6: held arrow repeats each quarter second
// RULE7: four seconds held gives step five
// RULE8: external amplitude ignores arrows, shows dashes
// RULE9: external amplitude from chosen analog input
// RULE10: overload lights alarm icon and output
// RULE11: latched alarm cleared by reset key/input
// RULE12: unlatched alarm cleared by start reassert
// RULE13: no restart within 20 ms of clear
// RULE14: select mode starts at 101, remembers
// RULE15: arrows move between registers
// RULE16: config key shows value, circle icon
// RULE17: value edit steps one, repeats, then five
// RULE18: reset key loads register default
// RULE19: config key stores, returns to amplitude
// RULE20: stored bit selects latching alarms
// RULE21: stored bit enables external amplitude
// RULE22: timers count clocks, restart on release
// RULE23: edits saturate at limits
module weld_panel
#(
    parameter int REPEAT_CYCLES_P  = weld_panel_pkg::REPEAT_CYCLES,
    parameter int HOLD_TICKS_P     = weld_panel_pkg::HOLD_TICKS,
    parameter int RESTART_CYCLES_P = weld_panel_pkg::RESTART_CYCLES
)
(
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       factory_init,
    input  wire logic       key_config,
    input  wire logic       key_up,
    input  wire logic       key_down,
    input  wire logic       key_reset,
    input  wire logic       ext_start,
    input  wire logic       ext_reset,
    input  wire logic       overload,
    input  wire logic [6:0] analog_a,
    input  wire logic [6:0] analog_b,
    input  wire logic [7:0] reg_addr,
    input  wire logic [9:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [9:0] reg_rdata,
    output logic            sonic_enable,
    output logic            general_alarm,
    output logic      [6:0] amplitude,
    output logic      [9:0] disp_value,
    output logic            disp_dashes,
    output logic            icon_percent,
    output logic            icon_number,
    output logic            icon_circle,
    output logic            icon_alarm
);
    import weld_panel_pkg::*;

    localparam int RW = $clog2(RESTART_CYCLES_P + 1);
    localparam logic [4:0] AMP_IDX = reg_index(REG_AMPLITUDE);  // amplitude slot in store

    // pin order in the sync vectors
    localparam int P_CFG   = 0;
    localparam int P_UP    = 1;
    localparam int P_DOWN  = 2;
    localparam int P_RST   = 3;
    localparam int P_START = 4;
    localparam int P_XRST  = 5;

    logic [5:0]    pin_meta;          // first stage, read only by the second
    logic [5:0]    pin_sync;          // pins in the clock domain
    logic [5:0]    pin_prev;          // pin_sync one cycle ago
    logic [5:0]    pin_rise;          // press or assert edges
    logic [9:0]    store [0:REG_COUNT-1];  // retained configuration values
    mode_t         mode;              // display mode
    logic [7:0]    sel_reg;           // register number chosen in select mode
    logic [9:0]    edit_val;          // value being edited
    logic          alarm;             // overload alarm, sticky
    logic [RW-1:0] holdoff;           // restart quiet time after an alarm clear
    logic          analog_sel;        // 0 picks analog_a, 1 picks analog_b
    logic          latching;          // latching alarm setting
    logic          ext_amp;           // external amplitude setting
    logic          alarm_clr;         // clear request for this cycle
    logic [4:0]    sel_idx;           // storage index of sel_reg
    logic [4:0]    wr_idx;            // storage index of reg_addr
    reg_limits_t   sel_lim;           // limits of the selected register
    reg_limits_t   wr_lim;            // limits of the addressed register
    logic [6:0]    ext_level;         // analog input chosen for amplitude
    logic          cfg_press;         // config key press edge
    logic          rst_press;         // reset key press edge

    key_step_if keys ();

    assign pin_rise  = pin_sync & ~pin_prev;
    assign cfg_press = pin_rise[P_CFG];
    assign rst_press = pin_rise[P_RST];
    assign sel_idx   = reg_index(sel_reg);
    assign wr_idx    = reg_index(reg_addr);
    assign sel_lim   = REG_TABLE[sel_idx];
    assign wr_lim    = REG_TABLE[wr_idx];
    assign latching  = store[reg_index(REG_LATCH)][0];    // RULE20
    assign ext_amp   = store[reg_index(REG_EXT_AMP)][0];  // RULE21
    assign ext_level = analog_sel ? analog_b : analog_a;  // RULE9
    assign keys.up   = pin_sync[P_UP];
    assign keys.down = pin_sync[P_DOWN];

    // arrow keys to step pulses
    key_repeat #(
        .REPEAT_CYCLES_P (REPEAT_CYCLES_P),
        .HOLD_TICKS_P    (HOLD_TICKS_P)
    ) u_repeat (
        .clock (clock),
        .srst  (srst),
        .keys  (keys.rpt)
    );

    // two-stage synchroniser for the key, start and reset pins, plus the edge history
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
            pin_prev <= '0;
        end
        else
        begin
            pin_meta <= {ext_reset, ext_start, key_reset, key_down, key_up, key_config};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // display mode sequence driven by the config key
    always_ff @(posedge clock)
    begin
        if (srst)
            mode <= MODE_AMP;  // RULE3
        else if (cfg_press)
        begin
            case (mode)
                MODE_AMP: mode <= MODE_SEL;  // RULE4
                MODE_SEL: mode <= MODE_VAL;  // RULE16
                MODE_VAL: mode <= MODE_AMP;  // RULE19
                default:  mode <= MODE_AMP;
            endcase
        end
    end

    // selected register number, kept across visits
    always_ff @(posedge clock)
    begin
        if (srst)
            sel_reg <= REG_FIRST;  // RULE14
        else if ((mode == MODE_SEL) && keys.step)
            sel_reg <= 8'(sat_step({2'b00, sel_reg}, keys.step_up, 1'b0,
                                   {2'b00, REG_FIRST}, {2'b00, REG_LAST}));  // RULE15 RULE23
    end

    // edited value: loaded on entry, stepped, or reset to default
    always_ff @(posedge clock)
    begin
        if (srst)
            edit_val <= '0;
        else if ((mode == MODE_SEL) && cfg_press)
            edit_val <= store[sel_idx];  // RULE16
        else if ((mode == MODE_VAL) && rst_press)
            edit_val <= sel_lim.def;  // RULE18
        else if ((mode == MODE_VAL) && keys.step && !sel_lim.ro)
            edit_val <= sat_step(edit_val, keys.step_up, keys.step_big,
                                 sel_lim.min, sel_lim.max);  // RULE17 RULE23
    end

    // retained storage; only a factory_init reset reloads it
    always_ff @(posedge clock)
    begin
        if (srst && factory_init)
        begin
            for (int i = 0; i < REG_COUNT; i++)
                store[i] <= REG_TABLE[i].def;
        end
        else if (srst)
        begin
            // RULE3: values survive a plain reset
        end
        else if ((mode == MODE_VAL) && cfg_press && !sel_lim.ro)
            store[sel_idx] <= edit_val;  // RULE19
        else if ((mode == MODE_AMP) && keys.step && !ext_amp)  // RULE8
            store[AMP_IDX] <= sat_step(store[AMP_IDX], keys.step_up, keys.step_big,
                                       REG_TABLE[AMP_IDX].min,
                                       REG_TABLE[AMP_IDX].max);  // RULE5 RULE6 RULE7 RULE23
        else if (reg_write && reg_mapped(reg_addr) && !wr_lim.ro)
            // software writes lose to a key edit in the same cycle
            store[wr_idx] <= clamp(reg_wdata, wr_lim.min, wr_lim.max);
    end

    // clear source follows the latching setting
    always_comb
    begin
        if (latching)
            alarm_clr = rst_press || pin_rise[P_XRST];  // RULE11
        else
            alarm_clr = pin_rise[P_START];  // RULE12
    end

    // overload alarm; a new overload wins over a clear in the same cycle
    always_ff @(posedge clock)
    begin
        if (srst)
            alarm <= 1'b0;
        else if (overload)
            alarm <= 1'b1;  // RULE10
        else if (alarm_clr)
            alarm <= 1'b0;  // RULE11 RULE12
    end

    // restart quiet time, armed when an alarm is cleared
    always_ff @(posedge clock)
    begin
        if (srst)
            holdoff <= '0;
        else if (alarm && alarm_clr && !overload)
            holdoff <= RW'(RESTART_CYCLES_P);  // RULE13
        else if (holdoff != '0)
            holdoff <= holdoff - 1'b1;
    end

    // ultrasonic output follows start, blocked by alarm and quiet time
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            sonic_enable  <= 1'b0;
            general_alarm <= 1'b0;
        end
        else
        begin
            sonic_enable  <= pin_sync[P_START] && !alarm && !overload
                             && (holdoff == '0);  // RULE1 RULE2 RULE13
            general_alarm <= alarm;  // RULE10
        end
    end

    // control register: analog input choice
    always_ff @(posedge clock)
    begin
        if (srst)
            analog_sel <= 1'b0;
        else if (reg_write && (reg_addr == ADDR_CONTROL))
            analog_sel <= reg_wdata[0];
    end

    // read port: data one cycle after the strobe, else zero
    always_ff @(posedge clock)
    begin
        if (srst || !reg_read)
            reg_rdata <= '0;
        else if (reg_mapped(reg_addr))
            reg_rdata <= store[wr_idx];
        else if (reg_addr == ADDR_CONTROL)
            reg_rdata <= {9'h000, analog_sel};
        else if (reg_addr == ADDR_STATUS)
        begin
            reg_rdata               <= '0;
            reg_rdata[ST_ALARM]     <= alarm;
            reg_rdata[ST_SONIC]     <= sonic_enable;
            reg_rdata[ST_HOLDOFF]   <= (holdoff != '0);
            reg_rdata[ST_MODE+:3]   <= mode;
        end
        else
            reg_rdata <= '0;  // unmapped addresses read as zero
    end

    // amplitude to the power stage, analog level clamped
    always_ff @(posedge clock)
    begin
        if (srst)
            amplitude <= '0;
        else if (ext_amp)
            amplitude <= 7'(clamp({3'b000, ext_level}, REG_TABLE[AMP_IDX].min,
                                  REG_TABLE[AMP_IDX].max));  // RULE9
        else
            amplitude <= store[AMP_IDX][6:0];
    end

    // display value and icons
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            disp_value   <= '0;
            disp_dashes  <= 1'b0;
            icon_percent <= 1'b0;
            icon_number  <= 1'b0;
            icon_circle  <= 1'b0;
            icon_alarm   <= 1'b0;
        end
        else
        begin
            icon_alarm   <= alarm;  // RULE10
            icon_percent <= (mode == MODE_AMP);  // RULE4
            icon_number  <= (mode == MODE_SEL);  // RULE14
            icon_circle  <= (mode == MODE_VAL);  // RULE16
            disp_dashes  <= (mode == MODE_AMP) && ext_amp;  // RULE8
            case (mode)
                MODE_AMP: disp_value <= ext_amp ? 10'h000 : store[AMP_IDX];  // RULE3 RULE8
                MODE_SEL: disp_value <= {2'b00, sel_reg};
                MODE_VAL: disp_value <= edit_val;
                default:  disp_value <= '0;
            endcase
        end
    end

endmodule : weld_panel

// file: hw/weld_panel_pkg.sv
package weld_panel_pkg;

    // clock rate and panel timings
    localparam int CLOCK_HZ       = 200_000_000;
    localparam int REPEAT_MS      = 250;   // auto-repeat period while an arrow is held
    localparam int HOLD_MS        = 4000;  // hold time before the big step applies
    localparam int RESTART_MS     = 20;    // least quiet time after an alarm reset

    // cycle counts; whole milliseconds keep each product inside an int
    localparam int REPEAT_CYCLES  = (CLOCK_HZ / 1000) * REPEAT_MS;
    localparam int RESTART_CYCLES = (CLOCK_HZ / 1000) * RESTART_MS;
    localparam int HOLD_TICKS     = HOLD_MS / REPEAT_MS;

    // edit steps
    localparam logic [9:0] STEP_SMALL = 10'h001;
    localparam logic [9:0] STEP_BIG   = 10'h005;

    // configuration register numbers, used directly as bus addresses
    localparam logic [7:0] REG_FIRST      = 8'h65;  // first register shown in select mode
    localparam logic [7:0] REG_LAST       = 8'h81;  // amplitude register, last one held
    localparam logic [7:0] REG_LATCH      = 8'h67;  // latching alarms bit
    localparam logic [7:0] REG_EXT_AMP    = 8'h68;  // external amplitude bit
    localparam logic [7:0] REG_AMPLITUDE  = 8'h81;
    localparam logic [7:0] ADDR_CONTROL   = 8'hf0;  // bit 0 picks the analog input
    localparam logic [7:0] ADDR_STATUS    = 8'hf1;
    localparam int         REG_COUNT      = 29;

    // status register field positions
    localparam int ST_ALARM   = 0;
    localparam int ST_SONIC   = 1;
    localparam int ST_HOLDOFF = 2;
    localparam int ST_MODE    = 3;

    // panel display modes, one-hot
    typedef enum logic [2:0]
    {
        MODE_AMP = 3'b001,  // amplitude shown, percent icon
        MODE_SEL = 3'b010,  // register number shown, number icon
        MODE_VAL = 3'b100   // register value shown, circle icon
    } mode_t;

    // one table entry: read-only flag, limits and default
    typedef struct packed
    {
        logic       ro;
        logic [9:0] min;
        logic [9:0] max;
        logic [9:0] def;
    } reg_limits_t;

    // entries from register 101 on, fields {ro, min, max, def}, ro one bit and the rest ten bits each
    localparam reg_limits_t REG_TABLE [0:REG_COUNT-1] = '{
        31'h400f9c00, 31'h00000400, 31'h00000400, 31'h00000400, 31'h001f9c50, 31'h00000401,
        31'h00000801, 31'h001f9c50, 31'h00000400, 31'h001f9df4, 31'h00000400, 31'h40000000,
        31'h40000000, 31'h40000000, 31'h00000800, 31'h4003fcc0, 31'h4003fca8, 31'h4003fc0a,
        31'h4003fc64, 31'h4003fc00, 31'h4003fc00, 31'h4003fc00, 31'h4003fc00, 31'h4003fcff,
        31'h4003fcff, 31'h4003fcff, 31'h4003fc00, 31'h00000c02, 31'h00a19064
    };

    // true when a register number has storage behind it
    function automatic logic reg_mapped(input logic [7:0] num);
        return (num >= REG_FIRST) && (num <= REG_LAST);
    endfunction : reg_mapped

    // storage index of a mapped register number
    function automatic logic [4:0] reg_index(input logic [7:0] num);
        return 5'(num - REG_FIRST);
    endfunction : reg_index

    // step a value up or down, saturating at the limits instead of wrapping
    function automatic logic [9:0] sat_step(input logic [9:0] val, input logic up,
                                            input logic big, input logic [9:0] lo,
                                            input logic [9:0] hi);
        logic [10:0] step;
        logic [10:0] sum;
        step = {1'b0, (big ? STEP_BIG : STEP_SMALL)};
        if (up)
        begin
            sum = {1'b0, val} + step;
            return (sum > {1'b0, hi}) ? hi : sum[9:0];
        end
        return ({1'b0, val} < ({1'b0, lo} + step)) ? lo : val - step[9:0];
    endfunction : sat_step

    // clamp a written value into the limits
    function automatic logic [9:0] clamp(input logic [9:0] val, input logic [9:0] lo,
                                         input logic [9:0] hi);
        return (val < lo) ? lo : ((val > hi) ? hi : val);
    endfunction : clamp

endpackage : weld_panel_pkg

// file: test/panel_partner.sv
// operator keys and automation lines; keys: 0 config, 1 up, 2 down, 3 reset
module panel_partner #(
    parameter int GAP_P = 12
)
(
    input  wire logic       clock,
    output logic      [3:0] keys,
    output logic            ext_start,
    output logic            ext_reset
);
    timeunit 1ns;
    timeprecision 1ps;

    // all lines idle at time zero
    initial
        {keys, ext_start, ext_reset} = 6'h00;

    // press, hold n cycles, then a quiet gap so the display settles
    task automatic tap(input int k, input int n);
        keys[k] <= 1'b1;
        repeat (n) @(posedge clock);
        keys[k] <= 1'b0;
        repeat (10) @(posedge clock);
    endtask : tap

    task automatic start_on(input logic v);
        ext_start <= v;
        @(posedge clock);
    endtask : start_on

    // drop start for GAP_P cycles, then apply it again as a fresh start edge
    task automatic restart();
        ext_start <= 1'b0;
        repeat (GAP_P) @(posedge clock);
        ext_start <= 1'b1;
        @(posedge clock);
    endtask : restart

    task automatic pulse_reset();
        ext_reset <= 1'b1;
        repeat (4) @(posedge clock);
        ext_reset <= 1'b0;
        repeat (4) @(posedge clock);
    endtask : pulse_reset
endmodule : panel_partner

// file: test/tb_weld_panel.sv
module tb_weld_panel;
    timeunit 1ns;
    timeprecision 1ps;
    import weld_panel_pkg::*;
    logic       clock, srst, factory_init, overload, reg_write, reg_read;
    logic       ext_start, ext_reset, sonic_enable, general_alarm, disp_dashes;
    logic       icon_percent, icon_number, icon_circle, icon_alarm;
    logic [3:0] keys;
    logic [6:0] analog_a, analog_b, amplitude;
    logic [7:0] reg_addr;
    logic [9:0] reg_wdata, reg_rdata, disp_value, got, p;
    int         num_errors, samples_checked, a0;
    // key, shown value (-1 = amplitude) and icons {percent,number,circle}
    int k_seq [11] = '{0, 1, 0, 1, 1, 3, 1, 0, 0, 0, 0};
    int d_seq [11] = '{101, 102, 0, 1, 1, 0, 1, -1, 102, 1, -1};
    int m_seq [11] = '{2, 2, 1, 1, 1, 1, 1, 4, 2, 1, 4};

    weld_panel #(.REPEAT_CYCLES_P(20), .HOLD_TICKS_P(4), .RESTART_CYCLES_P(10)) i_weld_panel (
        .clock(clock), .srst(srst), .factory_init(factory_init), .key_config(keys[0]),
        .key_up(keys[1]), .key_down(keys[2]), .key_reset(keys[3]), .ext_start(ext_start),
        .ext_reset(ext_reset), .overload(overload), .analog_a(analog_a), .analog_b(analog_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .sonic_enable(sonic_enable),
        .general_alarm(general_alarm), .amplitude(amplitude), .disp_value(disp_value),
        .disp_dashes(disp_dashes), .icon_percent(icon_percent), .icon_number(icon_number),
        .icon_circle(icon_circle), .icon_alarm(icon_alarm));
    panel_partner i_panel_partner (.clock(clock), .keys(keys), .ext_start(ext_start),
        .ext_reset(ext_reset));

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] seen);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : chk

    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    task automatic wr(input logic [7:0] a, input logic [9:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 got = reg_rdata;
    endtask : rd

    task automatic rst(input logic f);
        @(posedge clock);
        srst <= 1'b1;
        factory_init <= f;
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        factory_init <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask : rst

    // bounded wait for the shown number to move
    task automatic wait_change();
        logic [9:0] old;
        old = disp_value;
        for (int n = 0; n < 100; n++)
        begin
            @(posedge clock);
            #1;
            if (disp_value !== old)
                return;
        end
        num_errors++;
        end_sim();
    endtask : wait_change

    task automatic overload_pulse();
        @(posedge clock);
        overload <= 1'b1;
        @(posedge clock);
        overload <= 1'b0;
        repeat (4) @(posedge clock);
        #1 chk("alarm set", 10'h001, {9'h0, general_alarm});
    endtask : overload_pulse

    initial
    begin
        {num_errors, samples_checked} = 0;
        {srst, factory_init} = 2'h3;
        {reg_write, reg_read, overload, reg_addr, reg_wdata} = 21'h000000;
        analog_a = 7'h28;
        analog_b = 7'h00;
        void'($urandom(32'hc61b));
        rst(1'b1);
        rd(8'h67);
        chk("latch bit", 10'h000, got);
        rd(8'h68);
        chk("ext bit", 10'h000, got);
        for (int i = 0; i < 11; i++)
        begin
            i_panel_partner.tap(k_seq[i], 4);
            chk("panel", 10'((d_seq[i] < 0) ? 100 : d_seq[i]), disp_value);
            chk("icons", 10'(m_seq[i]), {7'h0, icon_percent, icon_number, icon_circle});
        end
        rd(8'h66);
        chk("stored value", 10'h001, got);
        a0 = $urandom_range(20, 60);
        wr(8'h81, 10'(a0));
        rst(1'b0);
        chk("stored amp", 10'(a0), disp_value);
        i_panel_partner.tap(1, 4);
        chk("amp step", 10'(a0 + 1), disp_value);
        fork
            i_panel_partner.tap(1, 130);
            for (int j = 0; j < 6; j++)
            begin
                p = disp_value;
                wait_change();
                chk("amp repeat", p + ((j >= 4) ? 10'h005 : 10'h001), disp_value);
            end
        join
        wr(8'h81, 10'h00b);
        repeat (2) i_panel_partner.tap(2, 4);
        chk("amp floor", 10'h00a, disp_value);
        wr(8'h68, 10'h001);
        wr(8'hf0, 10'h001);
        analog_b <= 7'($urandom_range(10, 100));
        i_panel_partner.tap(1, 4);
        chk("ext amp", {3'h0, analog_b}, {3'h0, amplitude});
        chk("dashes", 10'h001, {9'h0, disp_dashes});
        wr(8'hf0, 10'h000);
        repeat (4) @(posedge clock);
        #1 chk("ext amp a", {3'h0, analog_a}, {3'h0, amplitude});
        wr(8'h68, 10'h000);
        i_panel_partner.start_on(1'b1);
        repeat (20) @(posedge clock);
        #1 chk("sonic on", 10'h001, {9'h0, sonic_enable});
        overload_pulse();
        chk("sonic off", 10'h000, {9'h0, sonic_enable});
        i_panel_partner.restart();
        repeat (6) @(posedge clock);
        #1 chk("alarm clear", 10'h000, {9'h0, general_alarm});
        chk("holdoff", 10'h000, {9'h0, sonic_enable});
        repeat (20) @(posedge clock);
        #1 chk("restart", 10'h001, {9'h0, sonic_enable});
        wr(8'h67, 10'h001);
        for (int i = 0; i < 2; i++)
        begin
            overload_pulse();
            i_panel_partner.restart();
            #1 chk("alarm held", 10'h001, {9'h0, general_alarm});
            if (i == 0)
                i_panel_partner.pulse_reset();
            else
                i_panel_partner.tap(3, 4);
            repeat (20) @(posedge clock);
            #1 chk("latch clear", 10'h000, {9'h0, general_alarm});
            chk("relaunch", 10'h001, {9'h0, sonic_enable});
        end
        end_sim();
    end

    initial
    begin
        repeat (100000) @(posedge clock);
        num_errors++;
        end_sim();
    end
endmodule : tb_weld_panel

// file: test/weld_panel_checker.sv
module weld_panel_checker (
    input logic       clock,
    input logic       srst,
    input logic       overload,
    input logic       ext_start,
    input logic       sonic_enable,
    input logic       general_alarm,
    input logic       icon_alarm,
    input logic [9:0] disp_value,
    input logic       disp_dashes,
    input logic       icon_percent,
    input logic       icon_number,
    input logic       icon_circle
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    // alarm reaches the pin, with the icon beside it
    sequence s_alarm_up;
        ##[1:3] general_alarm ##0 icon_alarm;
    endsequence

    a_overload_alarm: assert property (overload |-> s_alarm_up)
        else $error("no alarm after overload");
    a_alarm_icon_pin: assert property (icon_alarm == general_alarm)
        else $error("alarm icon and pin differ");
    a_overload_quiet: assert property (overload |=> !sonic_enable)
        else $error("output on in overload");
    a_start_low_off: assert property (!ext_start [*4] |-> !sonic_enable)
        else $error("output on without start");
    // the bench quiet time is ten cycles, so eight is safe
    a_restart_gap: assert property ($fell(general_alarm) |-> !sonic_enable [*8])
        else $error("restart too soon");
    a_dash_blank: assert property (disp_dashes |-> disp_value == 10'h000)
        else $error("dashes over a number");
    a_one_icon: assert property ($onehot0({icon_percent, icon_number, icon_circle}))
        else $error("two mode icons lit");
    a_amp_range: assert property (icon_percent && !disp_dashes |->
        disp_value inside {[10:100]})
        else $error("amplitude out of range");
    a_sel_range: assert property (icon_number |-> disp_value inside {[101:129]})
        else $error("register number outside the table");
endmodule : weld_panel_checker

bind weld_panel weld_panel_checker i_weld_panel_checker (
    .clock(clock), .srst(srst), .overload(overload), .ext_start(ext_start),
    .sonic_enable(sonic_enable), .general_alarm(general_alarm), .icon_alarm(icon_alarm),
    .disp_value(disp_value), .disp_dashes(disp_dashes), .icon_percent(icon_percent),
    .icon_number(icon_number), .icon_circle(icon_circle));
